// File: fbled_pkg.sv
package fbled_pkg;

    // ============================================================
    // Clock and timing
    localparam int unsigned FBLED_CLK_PERIOD_NS = 10;
    localparam int unsigned FBLED_TICK_MS = 50;
    localparam int unsigned FBLED_TICK_CYCLES = FBLED_TICK_MS * 1000000 / FBLED_CLK_PERIOD_NS;
    localparam int unsigned FBLED_BASE_INIT_MS = 1500;
    localparam int unsigned FBLED_WAIT_UNIT_MS = 100;
    localparam int unsigned FBLED_BASE_INIT_TICKS = FBLED_BASE_INIT_MS / FBLED_TICK_MS;
    localparam int unsigned FBLED_WAIT_UNIT_TICKS = FBLED_WAIT_UNIT_MS / FBLED_TICK_MS;
    localparam logic [15:0] FBLED_WAIT_MAX = 16'h0064;

    // ============================================================
    // Lamp pattern timing, in 50 ms ticks
    localparam logic [5:0] FBLED_BLINK_TICKS = 6'h04;
    localparam logic [5:0] FBLED_FLASH_ON_TICKS = 6'h04;
    localparam logic [5:0] FBLED_SINGLE_PERIOD = 6'h18;
    localparam logic [5:0] FBLED_DOUBLE_PERIOD = 6'h20;

    // ============================================================
    // Register map
    localparam logic [15:0] FBLED_OFS_POWERUP_WAIT = 16'h3618;
    localparam logic [15:0] FBLED_OFS_COMM_EXT_SETUP = 16'h3722;
    localparam int unsigned FBLED_LINK_MODE_BIT = 11;
    localparam logic [15:0] FBLED_POWERUP_WAIT_RST = 16'h0000;
    localparam logic [15:0] FBLED_COMM_EXT_SETUP_RST = 16'h0000;

    // ============================================================
    // Types
    typedef enum logic [2:0] {
        FBLED_ESM_INIT,
        FBLED_ESM_BOOT,
        FBLED_ESM_PREOP,
        FBLED_ESM_SAFEOP,
        FBLED_ESM_OP
    } fbled_esm_t;

    typedef enum logic [2:0] {
        FBLED_ALM_NONE,
        FBLED_ALM_SETUP,
        FBLED_ALM_SYNC,
        FBLED_ALM_WATCHDOG,
        FBLED_ALM_INIT,
        FBLED_ALM_PDI
    } fbled_alarm_t;

    typedef struct packed {
        logic flicker;
        logic blink;
        logic single_flash;
        logic double_flash;
    } fbled_pattern_t;

    typedef struct packed {
        logic state_lamp;
        logic fault_lamp;
        logic port_in_lamp;
        logic port_out_lamp;
    } fbled_lamps_t;

    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fbled_reg_req_t;

endpackage

// File: fbled_pattern_gen.sv
`timescale 1ns/10ps
module fbled_pattern_gen
    import fbled_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tick,
    output fbled_pattern_t pattern
);

    logic flick_r;
    logic blink_r;
    logic [1:0] blink_cnt_r;
    logic [5:0] single_cnt_r;
    logic [5:0] double_cnt_r;
    wire single_wrap = (single_cnt_r == FBLED_SINGLE_PERIOD - 6'h01);
    wire double_wrap = (double_cnt_r == FBLED_DOUBLE_PERIOD - 6'h01);
    wire blink_wrap = (blink_cnt_r == 2'h3);

    // ============================================================
    // Free-running phase counters
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flick_r <= 1'b0;
            blink_r <= 1'b0;
            blink_cnt_r <= 2'h0;
            single_cnt_r <= 6'h00;
            double_cnt_r <= 6'h00;
        end else if (tick) begin
            flick_r <= ~flick_r;
            blink_cnt_r <= blink_cnt_r + 2'h1;
            if (blink_wrap) begin
                blink_r <= ~blink_r;
            end
            single_cnt_r <= single_wrap ? 6'h00 : single_cnt_r + 6'h01;
            double_cnt_r <= double_wrap ? 6'h00 : double_cnt_r + 6'h01;
        end
    end

    // Double flash: on 0-3, off 4-7, on 8-11, then 1000 ms dark
    assign pattern.flicker = flick_r;
    assign pattern.blink = blink_r;
    assign pattern.single_flash = (single_cnt_r < FBLED_FLASH_ON_TICKS);
    assign pattern.double_flash = (double_cnt_r < FBLED_FLASH_ON_TICKS) ||
        ((double_cnt_r >= 6'h08) && (double_cnt_r < 6'h0C));

endmodule

// File: fbled_status_led_driver.sv
`timescale 1ns/10ps
module fbled_status_led_driver
    import fbled_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = FBLED_TICK_CYCLES
)(
    input wire logic clk,
    input wire logic sys_rst,
    input fbled_esm_t esm_state,
    input fbled_alarm_t alarm_class,
    input wire logic comm_alarm_active,
    input wire logic link_in_pin,
    input wire logic act_in_pin,
    input wire logic link_out_pin,
    input wire logic act_out_pin,
    input fbled_reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    output fbled_lamps_t lamps,
    output logic init_done,
    output logic link_setup_variant_one
);

    // ============================================================
    // Registers
    logic [15:0] powerup_wait_time_r;
    logic [15:0] comm_extended_setup_r;
    wire sel_wait = (reg_req.addr == FBLED_OFS_POWERUP_WAIT);
    wire sel_ext = (reg_req.addr == FBLED_OFS_COMM_EXT_SETUP);
    // All 16 bits are stored; range limiting happens only where a value is used
    wire wr_wait = reg_req.wr && sel_wait;
    wire wr_ext = reg_req.wr && sel_ext;
    // Read data follows the address one cycle late; unmapped reads give zero
    wire [15:0] rdata_nxt = sel_wait ? powerup_wait_time_r :
        sel_ext ? comm_extended_setup_r : 16'h0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            powerup_wait_time_r <= FBLED_POWERUP_WAIT_RST;
            comm_extended_setup_r <= FBLED_COMM_EXT_SETUP_RST;
            reg_rdata <= 16'h0000;
        end else begin
            if (wr_wait) begin
                powerup_wait_time_r <= reg_req.wdata;
            end
            if (wr_ext) begin
                comm_extended_setup_r <= reg_req.wdata;
            end
            reg_rdata <= rdata_nxt;
        end
    end

    // Variant bit is only passed on; the link hardware acts on it
    assign link_setup_variant_one = comm_extended_setup_r[FBLED_LINK_MODE_BIT];

    // ============================================================
    // 50 ms tick divider
    // Restarts with reset, so every lamp pattern begins in the same phase
    // One-cycle enable; no second clock is derived
    logic [31:0] div_cnt_r;
    wire tick = (div_cnt_r == 32'(TICK_CYCLES - 1));
    wire [31:0] div_inc = div_cnt_r + 32'h0000_0001;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_cnt_r <= 32'h0000_0000;
        end else begin
            div_cnt_r <= tick ? 32'h0000_0000 : div_inc;
        end
    end

    // ============================================================
    // Pattern source
    // One shared generator keeps all lamps in step with each other
    fbled_pattern_t pat;

    fbled_pattern_gen u_pat (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(tick),
        .pattern(pat)
    );

    // ============================================================
    // Power-up wait
    // Setting is sampled live; values above 100 are clamped rather than refused
    wire [15:0] wait_clamped = (powerup_wait_time_r > FBLED_WAIT_MAX) ?
        FBLED_WAIT_MAX : powerup_wait_time_r;
    wire [15:0] init_target = 16'(FBLED_BASE_INIT_TICKS) +
        16'(wait_clamped * 16'(FBLED_WAIT_UNIT_TICKS));
    // Worst case of 230 ticks fits easily in sixteen bits
    logic [15:0] init_cnt_r;
    wire [15:0] init_cnt_inc = init_cnt_r + 16'h0001;
    wire init_reached = (init_cnt_inc >= init_target);

    // Counting stops once done, so the flag only falls again through reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            init_cnt_r <= 16'h0000;
            init_done <= 1'b0;
        end else if (tick && !init_done) begin
            init_cnt_r <= init_cnt_inc;
            init_done <= init_reached;
        end
    end

    // ============================================================
    // Pin synchronisers
    // Order: link_in, act_in, link_out, act_out
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic [3:0] pin_r;
    wire [3:0] pins_raw = {act_out_pin, link_out_pin, act_in_pin, link_in_pin};
    wire [3:0] agree = ~(s2_r ^ s3_r);
    wire [3:0] pin_nxt = (agree & s3_r) | (~agree & pin_r);

    // Only the second stage reads the first; a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
            s3_r <= 4'h0;
            pin_r <= 4'h0;
        end else begin
            s1_r <= pins_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= pin_nxt;
        end
    end

    // ============================================================
    // Settled pin levels
    wire link_in_ok = pin_r[0];
    wire act_in_ok = pin_r[1];
    wire link_out_ok = pin_r[2];
    wire act_out_ok = pin_r[3];
    wire [1:0] act_now = {act_out_ok, act_in_ok};

    // ============================================================
    // Activity stretch
    // Activity is a short pulse; stretch it over a whole flicker phase so it shows
    logic [1:0] act_seen_r;
    logic [1:0] act_hold_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            act_seen_r <= 2'h0;
            act_hold_r <= 2'h0;
        end else if (tick) begin
            act_hold_r <= act_seen_r | act_now;
            // A frame on the tick edge also counts for the next period
            act_seen_r <= act_now;
        end else begin
            act_seen_r <= act_seen_r | act_now;
        end
    end

    // ============================================================
    // Lamp selection
    // Link down wins over activity, so a dead port never flickers
    function automatic logic port_lamp(input logic link, input logic act, input logic flk);
        port_lamp = link && (act ? flk : 1'b1);
    endfunction

    logic state_nxt;
    logic fault_nxt;

    // Codes outside the enum light nothing rather than guess a pattern
    always_comb begin
        unique case (esm_state)
            FBLED_ESM_INIT: state_nxt = 1'b0;
            FBLED_ESM_BOOT: state_nxt = pat.flicker;
            FBLED_ESM_PREOP: state_nxt = pat.blink;
            FBLED_ESM_SAFEOP: state_nxt = pat.single_flash;
            FBLED_ESM_OP: state_nxt = 1'b1;
            default: state_nxt = 1'b0;
        endcase
    end

    always_comb begin
        unique case (alarm_class)
            FBLED_ALM_SETUP: fault_nxt = pat.blink;
            FBLED_ALM_SYNC: fault_nxt = pat.single_flash;
            FBLED_ALM_WATCHDOG: fault_nxt = pat.double_flash;
            FBLED_ALM_INIT: fault_nxt = pat.flicker;
            FBLED_ALM_PDI: fault_nxt = 1'b0;
            default: fault_nxt = 1'b0;
        endcase
    end

    // ============================================================
    // Lamp outputs
    // Gating by the alarm flag keeps a stale class from lighting the fault lamp
    wire fault_gated = comm_alarm_active && fault_nxt;
    wire port_in_nxt = port_lamp(link_in_ok, act_hold_r[0], pat.flicker);
    wire port_out_nxt = port_lamp(link_out_ok, act_hold_r[1], pat.flicker);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lamps <= '0;
        end else begin
            lamps.state_lamp <= state_nxt;
            lamps.fault_lamp <= fault_gated;
            lamps.port_in_lamp <= port_in_nxt;
            lamps.port_out_lamp <= port_out_nxt;
        end
    end

endmodule

// File: fbled_assertions.sv
`timescale 1ns/10ps
// ============================================================
// Lamp and register checks
module fbled_assertions
    import fbled_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = FBLED_TICK_CYCLES
)(
    input wire logic clk,
    input wire logic sys_rst,
    input fbled_esm_t esm_state,
    input fbled_alarm_t alarm_class,
    input wire logic comm_alarm_active,
    input wire logic link_in_pin,
    input wire logic link_out_pin,
    input wire logic act_out_pin,
    input fbled_reg_req_t reg_req,
    input logic [15:0] reg_rdata,
    input fbled_lamps_t lamps,
    input logic init_done,
    input logic link_setup_variant_one
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Activity is stretched, so idle is judged only after three ticks
    logic [15:0] idle_cnt;
    always_ff @(posedge clk) begin
        if (sys_rst || !link_out_pin || act_out_pin) begin
            idle_cnt <= 16'h0000;
        end else if (idle_cnt != 16'hFFFF) begin
            idle_cnt <= idle_cnt + 16'h0001;
        end
    end
    AST_RST: assert property (disable iff (1'b0) sys_rst |=> lamps == 4'h0 && !init_done)
        else $error("lamps or init not cleared by reset");
    AST_OP_ON: assert property (esm_state == FBLED_ESM_OP && $past(esm_state) == FBLED_ESM_OP
        |=> lamps.state_lamp) else $error("state lamp dark in operational");
    AST_INIT_OFF: assert property (esm_state == FBLED_ESM_INIT
        && $past(esm_state) == FBLED_ESM_INIT |=> !lamps.state_lamp) else $error("state lamp lit");
    AST_NO_ALM: assert property (!comm_alarm_active && !$past(comm_alarm_active)
        |=> !lamps.fault_lamp) else $error("fault lamp lit with no alarm");
    AST_PDI: assert property (alarm_class == FBLED_ALM_PDI && $past(alarm_class) == FBLED_ALM_PDI
        |=> !lamps.fault_lamp) else $error("fault lamp lit for interface class");
    AST_LINK_DOWN: assert property (!link_in_pin [*8] |=> !lamps.port_in_lamp)
        else $error("inbound lamp lit with link down");
    AST_LINK_IDLE: assert property (32'(idle_cnt) > 3 * TICK_CYCLES + 8 |-> lamps.port_out_lamp)
        else $error("outbound lamp dark on idle link");
    AST_VARIANT: assert property (reg_req.wr && reg_req.addr == FBLED_OFS_COMM_EXT_SETUP
        |=> link_setup_variant_one == $past(reg_req.wdata[11])) else $error("mode bit wrong");
    AST_UNMAPPED: assert property (reg_req.addr != FBLED_OFS_POWERUP_WAIT
        && reg_req.addr != FBLED_OFS_COMM_EXT_SETUP |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_INIT_STAYS: assert property (init_done |=> init_done) else $error("init done fell");
endmodule

bind fbled_status_led_driver fbled_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk, .sys_rst,
    .esm_state, .alarm_class, .comm_alarm_active, .link_in_pin, .link_out_pin, .act_out_pin,
    .reg_req, .reg_rdata, .lamps, .init_done, .link_setup_variant_one);

// File: fbled_lamp_viewer.sv
`timescale 1ns/10ps
// ============================================================
// Operator view: lit cycles per lamp over a window
module fbled_lamp_viewer
    import fbled_pkg::*;
(
    input wire logic clk,
    input wire logic clr,
    input fbled_lamps_t lamps,
    output logic [3:0][15:0] lit
);
    // Counting lit time hides pattern phase, so windows need not align to ticks
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            lit[i] <= clr ? 16'h0000 : lit[i] + 16'(lamps[i]);
        end
    end
endmodule

// File: fbled_status_led_driver_tb.sv
`timescale 1ns/10ps
// ============================================================
// Bench
module fbled_status_led_driver_tb;
    import fbled_pkg::*;
    localparam int TC = 10;
    logic clk = 0, sys_rst = 1, comm_alarm_active = 0, clr = 1, fin = 0, fout = 0;
    logic link_in_pin = 0, act_in_pin = 0, link_out_pin = 0, act_out_pin = 0;
    logic init_done, link_setup_variant_one;
    logic [15:0] reg_rdata, v;
    logic [3:0][15:0] lit;
    logic [2:0] cyc = 0;
    fbled_esm_t esm_state = FBLED_ESM_INIT;
    fbled_alarm_t alarm_class = FBLED_ALM_NONE;
    fbled_reg_req_t reg_req = '0;
    fbled_lamps_t lamps;
    int n_fail = 0, n_tests = 0, n, e;
    int st_k[5] = '{0, 1, 1, 2, 4};
    int ft_k[6] = '{0, 1, 2, 3, 1, 0};
    always #5 clk = ~clk;
    // Pulses held four cycles so the pin synchroniser accepts them
    always @(negedge clk) begin
        cyc <= cyc + 3'h1;
        act_in_pin <= fin & cyc[2];
        act_out_pin <= fout & cyc[2];
    end
    fbled_status_led_driver #(.TICK_CYCLES(TC)) dut (.clk, .sys_rst, .esm_state, .alarm_class,
        .comm_alarm_active, .link_in_pin, .act_in_pin, .link_out_pin, .act_out_pin, .reg_req,
        .reg_rdata, .lamps, .init_done, .link_setup_variant_one);
    fbled_lamp_viewer viewer (.clk, .clr, .lamps, .lit);
    task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
        n_tests++;
        if (g !== x) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, x, g);
        end
    endtask
    task automatic test_done;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
        reg_req = '{1'b1, a, d};
        @(negedge clk);
        reg_req.wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic reg_rd(input logic [15:0] a, input logic [15:0] x);
        reg_req.addr = a;
        @(negedge clk);
        chk("reg_rdata", x, reg_rdata);
    endtask
    // Lit cycles in 960, a whole number of periods of every pattern
    function automatic logic [15:0] pat(input int k);
        return (k == 0) ? 16'h0000 : (k == 1) ? 16'h01E0 : (k == 2) ? 16'h00A0
            : (k == 3) ? 16'h00F0 : 16'h03C0;
    endfunction
    task automatic init_run(input logic [15:0] wv);
        sys_rst = 1;
        repeat (3) @(negedge clk);
        sys_rst = 0;
        reg_wr(FBLED_OFS_POWERUP_WAIT, wv);
        n = 2;
        e = (30 + 2 * ((wv > 16'h0064) ? 100 : int'(wv))) * TC;
        while (init_done !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk("init_late", 16'h0000, 16'(n > e + 2 * TC || n + 2 * TC < e));
        reg_rd(FBLED_OFS_POWERUP_WAIT, wv);
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        test_done;
    end
    initial begin
        void'($urandom(38206));
        repeat (20) @(negedge clk);
        init_run(16'h0078);
        init_run(16'($urandom_range(100)));
        v = 16'($urandom) | 16'h0800;
        reg_wr(FBLED_OFS_COMM_EXT_SETUP, v);
        chk("variant", 16'h0001, 16'(link_setup_variant_one));
        reg_rd(FBLED_OFS_COMM_EXT_SETUP, v);
        reg_wr(FBLED_OFS_COMM_EXT_SETUP, v & 16'hF7FF);
        chk("variant", 16'h0000, 16'(link_setup_variant_one));
        reg_wr(16'h3619, 16'($urandom));
        reg_rd(16'h3619, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            esm_state = fbled_esm_t'(i % 5);
            alarm_class = (i < 5) ? fbled_alarm_t'(i + 1) : fbled_alarm_t'($urandom_range(5));
            comm_alarm_active = (i < 5);
            link_in_pin = (i != 0);
            fin = (i == 2);
            link_out_pin = (i != 1);
            fout = (i == 3);
            repeat (40) @(negedge clk);
            clr = 0;
            repeat (960) @(negedge clk);
            clr = 1;
            chk("state_lamp", pat(st_k[i % 5]), lit[3]);
            chk("fault_lamp", (i < 5) ? pat(ft_k[i + 1]) : 16'h0000, lit[2]);
            chk("port_in_lamp", pat(link_in_pin ? (fin ? 1 : 4) : 0), lit[1]);
            chk("port_out_lamp", pat(link_out_pin ? (fout ? 1 : 4) : 0), lit[0]);
        end
        test_done;
    end
endmodule
